// ===== hdl/hpsi_pkg.sv
// Package for the host port pin interface: constants, register map and carriers
package hpsi_pkg;

	localparam int unsigned DATA_W    = 16;
	localparam int unsigned ADDR_W    = 20;
	localparam int unsigned SYNC_W    = 3;
	localparam int unsigned MEM_WORDS = 1024;

	// AHB register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_RDATA  = 8'h0c;
	localparam logic [7:0] OFS_LATCH  = 8'h10;

	// Control register fields
	localparam int unsigned CTRL_HOLD_BIT   = 0;
	localparam int unsigned CTRL_MASK_BIT   = 1;
	localparam logic [1:0]  CTRL_RESET_VAL  = 2'h0;

	// Status register fields
	localparam int unsigned ST_PEND_BIT  = 0;
	localparam int unsigned ST_MODE_BIT  = 1;
	localparam int unsigned ST_DIR_BIT   = 2;
	localparam int unsigned ST_SEL_LSB   = 4;
	localparam int unsigned ST_COUNT_LSB = 8;

	// Shared-bus access select codes
	localparam logic [1:0] SEL_CTRL     = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDR     = 2'h2;
	localparam logic [1:0] SEL_DATA     = 2'h3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		HPSI_IDLE    = 2'h0,
		HPSI_STROBE  = 2'h1,
		HPSI_WAIT    = 2'h3,
		HPSI_DONE    = 2'h2
	} hpsi_state_type;

	// Pins from the host
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [ADDR_W-1:0] addr;
		logic              select_n;
		logic              read_write;
		logic              strobe_a;
		logic              strobe_b;
		logic              ctl0;
		logic              mode_sel;
	} hpsi_pin_in_type;

	// Pins toward the host; enables are low while driving
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              data_oe_n;
		logic              data_hold;
		logic              ready;
		logic              ready_oe_n;
	} hpsi_pin_out_type;

	// Host access as seen by the DSP side
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [1:0]        sel;
		logic              mode_sep;
		logic              is_read;
	} hpsi_access_type;

endpackage

// ===== hdl/hpsi_port.sv
// Host port pin front end with an AHB-Lite register slave for the DSP side
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - Separate-bus mode: the data lines carry data words only.
// - Shared-bus mode: the data lines carry addresses and data.
// - Data lines are released outside an active read transfer.
// - Undriven data lines keep last level when holders on, else float.
// - Separate-bus mode: 20-bit word address selects one of 1024K words.
// - Shared-bus mode: address line 1 is ctl1, line 2 address strobe.
// - Direction high means read from memory, low means write.
// - Internal strobe is XNOR of both strobes and times transfers.
// - Ready is low while the port is busy; host stretches its cycle.
// - Ready goes high once the transfer has finished.
// - Deselect tri-states ready at once, whatever the transfer state.
// - Mode select high means separate buses, low means shared bus.
// - Separate-bus mode: ctl0 low is address access, high is data access.
// - Shared-bus mode codes: control, data+inc, address, data.
module hpsi_port
	import hpsi_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic                     hready,
	input  wire logic [31:0]              hwdata,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire hpsi_pkg::hpsi_pin_in_type pin_in,
	output hpsi_pkg::hpsi_pin_out_type     pin_out,
	output hpsi_pkg::hpsi_access_type      access_out
);
	import hpsi_pkg::*;

	// Three-stage synchronisers; stage 0 feeds only stage 1
	logic [SYNC_W-1:0] sel_n_s_q, rw_s_q, dsa_s_q, dsb_s_q, ctl0_s_q, mode_s_q, astb_s_q;
	logic [SYNC_W-1:0] ctl1_s_q;
	logic [DATA_W-1:0] data_s0_q, data_s1_q, data_s2_q;
	logic [ADDR_W-1:0] addr_s0_q, addr_s1_q, addr_s2_q;
	logic              sel_n_q, rw_q, dsa_q, dsb_q, ctl0_q, ctl1_q, mode_q, astb_q;

	function automatic logic settle(input logic [SYNC_W-1:0] s, input logic old);
		return (s[1] == s[2]) ? s[2] : old;
	endfunction

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sel_n_s_q <= '1;
			rw_s_q    <= '1;
			dsa_s_q   <= '1;
			dsb_s_q   <= '1;
			ctl0_s_q  <= '0;
			ctl1_s_q  <= '0;
			mode_s_q  <= '1;
			astb_s_q  <= '1;
			data_s0_q <= '0;
			data_s1_q <= '0;
			data_s2_q <= '0;
			addr_s0_q <= '0;
			addr_s1_q <= '0;
			addr_s2_q <= '0;
		end
		else
		begin
			sel_n_s_q <= {sel_n_s_q[1:0], pin_in.select_n};
			rw_s_q    <= {rw_s_q[1:0], pin_in.read_write};
			dsa_s_q   <= {dsa_s_q[1:0], pin_in.strobe_a};
			dsb_s_q   <= {dsb_s_q[1:0], pin_in.strobe_b};
			ctl0_s_q  <= {ctl0_s_q[1:0], pin_in.ctl0};
			ctl1_s_q  <= {ctl1_s_q[1:0], pin_in.addr[1]};
			mode_s_q  <= {mode_s_q[1:0], pin_in.mode_sel};
			astb_s_q  <= {astb_s_q[1:0], pin_in.addr[2]};
			data_s0_q <= pin_in.data;
			data_s1_q <= data_s0_q;
			data_s2_q <= data_s1_q;
			addr_s0_q <= pin_in.addr;
			addr_s1_q <= addr_s0_q;
			addr_s2_q <= addr_s1_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sel_n_q <= 1'b1;
			rw_q    <= 1'b1;
			dsa_q   <= 1'b1;
			dsb_q   <= 1'b1;
			ctl0_q  <= 1'b0;
			ctl1_q  <= 1'b0;
			mode_q  <= 1'b1;
			astb_q  <= 1'b1;
		end
		else
		begin
			sel_n_q <= settle(sel_n_s_q, sel_n_q);
			rw_q    <= settle(rw_s_q, rw_q);
			dsa_q   <= settle(dsa_s_q, dsa_q);
			dsb_q   <= settle(dsb_s_q, dsb_q);
			ctl0_q  <= settle(ctl0_s_q, ctl0_q);
			ctl1_q  <= settle(ctl1_s_q, ctl1_q);
			mode_q  <= settle(mode_s_q, mode_q);
			astb_q  <= settle(astb_s_q, astb_q);
		end
	end

	// Strobe active low; either host strobe style works with the XNOR
	logic strobe_n;
	logic [1:0] sel_code;
	assign strobe_n = ~(dsa_q ^ dsb_q);
	// Shared bus: line 1 carries ctl1; separate bus: ctl1 unused
	assign sel_code = mode_q ? {1'b1, ctl0_q} : {ctl1_q, ctl0_q};

	// Controls latched while the address strobe is low; once it has pulsed,
	// the latch rules until the port leaves shared mode
	logic [1:0] latched_sel_q;
	logic       latched_rw_q;
	logic       astb_seen_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			latched_sel_q <= SEL_CTRL;
			latched_rw_q  <= 1'b1;
			astb_seen_q   <= 1'b0;
		end
		else if (mode_q)
			astb_seen_q <= 1'b0;
		else if (!astb_q)
		begin
			latched_sel_q <= sel_code;
			latched_rw_q  <= rw_q;
			astb_seen_q   <= 1'b1;
		end
	end

	logic [1:0] eff_sel;
	logic       eff_rw;
	logic       use_latch;
	// With the address strobe tied high, the live control lines are used
	assign use_latch = !mode_q && astb_seen_q && astb_q;
	assign eff_sel   = use_latch ? latched_sel_q : sel_code;
	assign eff_rw    = use_latch ? latched_rw_q : rw_q;

	// Software side registers
	logic [1:0]        ctrl_q;
	logic [DATA_W-1:0] rd_word_q;
	logic              pend_q;
	logic [7:0]        count_q;
	hpsi_state_type    state_q;
	hpsi_access_type   acc_q;
	logic              ack_set;

	// Port handshake
	logic start;
	assign start = (state_q == HPSI_IDLE) && !sel_n_q && !strobe_n;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_q <= HPSI_IDLE;
		else if (sel_n_q)
			state_q <= HPSI_IDLE;
		else
			unique case (state_q)
				HPSI_IDLE:   if (!strobe_n) state_q <= HPSI_STROBE;
				HPSI_STROBE: state_q <= HPSI_WAIT;
				HPSI_WAIT:   if (ack_set) state_q <= HPSI_DONE;
				HPSI_DONE:   if (strobe_n) state_q <= HPSI_IDLE;
			endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc_q <= '0;
		else if (start)
		begin
			acc_q.addr     <= mode_q ? addr_s2_q : '0;
			acc_q.data     <= data_s2_q;
			acc_q.sel      <= eff_sel;
			acc_q.mode_sep <= mode_q;
			acc_q.is_read  <= eff_rw;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pin_out <= '{data: '0, data_oe_n: 1'b1, data_hold: 1'b0, ready: 1'b0,
				ready_oe_n: 1'b1};
		else
		begin
			pin_out.ready_oe_n <= sel_n_q;
			pin_out.ready      <= !sel_n_q && (state_q == HPSI_DONE);
			pin_out.data_oe_n  <= !(!sel_n_q && state_q == HPSI_DONE && acc_q.is_read);
			pin_out.data_hold  <= ctrl_q[CTRL_HOLD_BIT];
			if (state_q == HPSI_DONE && acc_q.is_read)
				pin_out.data <= rd_word_q;
		end
	end

	assign access_out = acc_q;

	// AHB-Lite slave, zero wait states, always OKAY
	logic       ph_q;
	logic       ph_wr_q;
	logic [7:0] ph_ofs_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_q     <= 1'b0;
			ph_wr_q  <= 1'b0;
			ph_ofs_q <= '0;
		end
		else if (hready)
		begin
			ph_q     <= hsel && (htrans == HTRANS_NONSEQ);
			ph_wr_q  <= hwrite;
			ph_ofs_q <= haddr[7:0];
		end
	end

	assign ack_set = ph_q && ph_wr_q && (ph_ofs_q == OFS_WDATA);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q    <= CTRL_RESET_VAL;
			rd_word_q <= '0;
		end
		else if (ph_q && ph_wr_q)
		begin
			if (ph_ofs_q == OFS_CTRL)
				ctrl_q <= hwdata[1:0];
			if (ph_ofs_q == OFS_WDATA)
				rd_word_q <= hwdata[DATA_W-1:0];
		end
	end

	// Pending flag: set on new access beats software clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pend_q <= 1'b0;
		else if (start)
			pend_q <= 1'b1;
		else if (ack_set)
			pend_q <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_q <= '0;
		else if (start)
			count_q <= 8'(count_q + 8'h01);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite)
			unique case (haddr[7:0])
				OFS_CTRL:   hrdata <= {30'h0, ctrl_q};
				OFS_STATUS: hrdata <= {16'h0, count_q, 2'h0, acc_q.sel, 1'b0,
					acc_q.is_read, acc_q.mode_sep, pend_q};
				OFS_RDATA:  hrdata <= {16'h0, acc_q.data};
				OFS_LATCH:  hrdata <= {12'h0, acc_q.addr};
				default:    hrdata <= '0;
			endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	a_ready_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
		sel_n_q |=> pin_out.ready_oe_n && !pin_out.ready)
		else $error("ready not released after deselect");
	a_ready_done: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == HPSI_DONE && !sel_n_q) |=> pin_out.ready)
		else $error("ready not raised after completion");
	a_ready_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == HPSI_WAIT) |=> !pin_out.ready)
		else $error("ready high while busy");
	a_data_release: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == HPSI_IDLE) |=> pin_out.data_oe_n)
		else $error("data driven outside transfer");
	a_hold_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> pin_out.data_hold == $past(ctrl_q[CTRL_HOLD_BIT]))
		else $error("holder enable wrong");
	a_start_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
		start |-> (dsa_q != dsb_q))
		else $error("start without strobe");
	a_dir_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		(start && !use_latch) |=> acc_q.is_read == $past(rw_q))
		else $error("direction not captured");
	a_addr_sep: assert property (@(posedge hclk) disable iff (!hresetn)
		(start && mode_q) |=> acc_q.addr == $past(addr_s2_q))
		else $error("address not captured");
	a_sel_shared: assert property (@(posedge hclk) disable iff (!hresetn)
		(start && !mode_q && !use_latch) |=> acc_q.sel == {$past(ctl1_q), $past(ctl0_q)})
		else $error("shared select wrong");
	a_latch_used: assert property (@(posedge hclk) disable iff (!hresetn)
		(start && use_latch) |=> acc_q.sel == $past(latched_sel_q))
		else $error("latched select not used");
	a_data_word: assert property (@(posedge hclk) disable iff (!hresetn)
		start |=> acc_q.data == $past(data_s2_q))
		else $error("data word not captured");

endmodule

// ===== tb/hpsi_host_model.sv
// Host processor model: drives the port pins and resolves the data bus
`timescale 1ns/10ps
module hpsi_host_model
(
	input  wire logic                       hclk,
	output hpsi_pkg::hpsi_pin_in_type       pin_in,
	input  wire hpsi_pkg::hpsi_pin_out_type pin_out
);
	import hpsi_pkg::*;
	hpsi_pin_in_type   pins;
	logic              drv;
	logic [DATA_W-1:0] word;
	logic [DATA_W-1:0] last;
	logic [DATA_W-1:0] bus;
	logic [1:0]        sty;
	initial
	begin
		pins = '0;
		pins.select_n = 1'h1;
		{pins.strobe_a, pins.strobe_b} = 2'h3;
		pins.addr = 20'h4;
		drv = 1'h0;
		last = '0;
		sty = '0;
	end
	// Style bit 1 is the strobe polarity, bit 0 picks the pulsing line
	task automatic start(input logic m, cs, rw, input logic [1:0] s, st,
		input logic [19:0] a, input logic [15:0] w);
		@(posedge hclk);
		sty <= st;
		pins.mode_sel <= m;
		pins.select_n <= cs;
		pins.read_write <= rw;
		pins.ctl0 <= s[0];
		pins.addr <= m ? a : {17'h0, 1'h1, s[1], 1'h0};
		{pins.strobe_a, pins.strobe_b} <= {2{~st[1]}};
		drv <= !rw;
		word <= w;
		@(posedge hclk);
		if (st[0])
			pins.strobe_b <= st[1];
		else
			pins.strobe_a <= st[1];
	endtask
	task automatic stop();
		@(posedge hclk);
		{pins.strobe_a, pins.strobe_b} <= {2{~sty[1]}};
		drv <= 1'h0;
		@(posedge hclk);
		pins.select_n <= 1'h1;
	endtask
	// Released lines without holders show the inverse so stale data never matches
	always_comb
	begin
		bus = ~last;
		if (drv)
			bus = word;
		else if (!pin_out.data_oe_n)
			bus = pin_out.data;
		else if (pin_out.data_hold)
			bus = last;
		pin_in = pins;
		pin_in.data = bus;
	end
	always @(posedge hclk)
		if (drv || !pin_out.data_oe_n)
			last <= bus;
endmodule

// ===== tb/hpsi_port_tb.sv
// Self-checking bench for the host port pin front end
`timescale 1ns/10ps
module hpsi_port_tb;
	import hpsi_pkg::*;
	logic             hclk;
	logic             hresetn;
	logic             hsel;
	logic             hwrite;
	logic             hready;
	logic [1:0]       htrans;
	logic [31:0]      haddr;
	logic [31:0]      hwdata;
	logic [31:0]      hrdata;
	logic [31:0]      rd;
	logic             hresp;
	hpsi_access_type  access_out;
	int               n_mismatch;
	int               checks_done;
	int               cyc;
	hpsi_pin_in_type  pin_in;
	hpsi_pin_out_type pin_out;
	hpsi_port i_hpsi_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
		.access_out(access_out));
	hpsi_host_model i_hpsi_host_model (.hclk(hclk), .pin_in(pin_in), .pin_out(pin_out));
	always #5 hclk = ~hclk;
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e, input string m);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'h1)
			@(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'h1)
			@(posedge hclk);
		rd = hrdata;
		chk(hresp, 32'h0, "response not okay");
	endtask
	task automatic pend();
		rd = '0;
		for (int i = 0; i < 10 && rd[ST_PEND_BIT] !== 1'h1; i++)
			ahb(1'h0, OFS_STATUS, 32'h0);
		chk(rd[ST_PEND_BIT], 1'h1, "access not taken");
	endtask
	task automatic xfer(input logic m, rw, input logic [1:0] s, st,
		input logic [19:0] a, input logic [15:0] w);
		i_hpsi_host_model.start(m, 1'h0, rw, s, st, a, w);
		pend();
		chk({rd[ST_SEL_LSB+1] & ~m, rd[ST_SEL_LSB+:1], rd[ST_DIR_BIT], rd[ST_MODE_BIT]},
			{s[1] & ~m, s[0], rw, m}, "status");
		chk({access_out.mode_sep, access_out.is_read}, {m, rw}, "access view");
		chk({pin_out.ready_oe_n, pin_out.ready}, 2'h0, "ready not low");
		ahb(1'h0, OFS_RDATA, 32'h0);
		if (!rw)
			chk(rd[15:0], w, "write word");
		ahb(1'h0, OFS_LATCH, 32'h0);
		chk(rd[19:0], m ? a : 20'h0, "address");
		ahb(1'h1, OFS_WDATA, {16'h0, ~w});
		for (int i = 0; i < 10 && pin_out.ready !== 1'h1; i++)
			@(posedge hclk);
		chk({pin_out.ready_oe_n, pin_out.ready}, 2'h1, "ready not high");
		if (rw)
			chk({pin_out.data_oe_n, pin_in.data}, {1'h0, ~w}, "read word");
		else
			chk(pin_out.data_oe_n, 1'h1, "bus driven on write");
		i_hpsi_host_model.stop();
		for (int i = 0; i < 10 && pin_out.data_oe_n !== 1'h1; i++)
			@(posedge hclk);
		chk(pin_out.data_oe_n, 1'h1, "bus not released");
	endtask
	task automatic t_reset();
		chk({pin_out.data_oe_n, pin_out.ready_oe_n}, 2'h3, "pins driven");
		ahb(1'h1, 8'h20, 32'h3);
		ahb(1'h0, 8'h20, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		ahb(1'h0, OFS_CTRL, 32'h0);
		chk(rd, {30'h0, CTRL_RESET_VAL}, "ctrl reset");
	endtask
	task automatic t_sep();
		for (int i = 0; i < 8; i++)
			xfer(1'h1, i[2], {1'h0, i[0]}, i[1:0], 20'hffff8 + i[19:0], 16'ha5c0 + i[15:0]);
	endtask
	task automatic t_shared();
		for (int i = 0; i < 4; i++)
			xfer(1'h0, 1'h0, i[1:0], 2'h2, 20'h0, 16'h1230 + i[15:0]);
	endtask
	task automatic t_hold();
		ahb(1'h1, OFS_CTRL, 32'h1);
		repeat (2)
			@(posedge hclk);
		chk(pin_out.data_hold, 1'h1, "holder off");
		xfer(1'h1, 1'h1, 2'h1, 2'h1, 20'h00060, 16'h00ff);
		chk(pin_in.data, 16'hff00, "bus not held");
		ahb(1'h1, OFS_CTRL, 32'h0);
		repeat (2)
			@(posedge hclk);
		chk(pin_out.data_hold, 1'h0, "holder on");
		chk(pin_in.data, 16'h00ff, "bus still held");
	endtask
	task automatic t_ignore();
		i_hpsi_host_model.start(1'h1, 1'h1, 1'h0, 2'h1, 2'h0, 20'h00100, 16'h5555);
		repeat (10)
			@(posedge hclk);
		ahb(1'h0, OFS_STATUS, 32'h0);
		chk(rd[ST_PEND_BIT], 1'h0, "strobe taken while deselected");
		chk({pin_out.ready_oe_n, pin_out.data_oe_n}, 2'h3, "driven while deselected");
		i_hpsi_host_model.stop();
	endtask
	task automatic t_desel();
		i_hpsi_host_model.start(1'h1, 1'h0, 1'h0, 2'h1, 2'h3, 20'h00200, 16'h0f0f);
		pend();
		chk(pin_out.ready_oe_n, 1'h0, "ready not driven");
		@(posedge hclk);
		i_hpsi_host_model.pins.select_n <= 1'h1;
		for (int i = 0; i < 10 && pin_out.ready_oe_n !== 1'h1; i++)
			@(posedge hclk);
		chk(pin_out.ready_oe_n, 1'h1, "ready still driven");
		ahb(1'h1, OFS_WDATA, 32'h0);
		i_hpsi_host_model.stop();
	endtask
	task automatic t_astb();
		@(posedge hclk);
		i_hpsi_host_model.sty <= 2'h0;
		i_hpsi_host_model.pins.mode_sel <= 1'h0;
		i_hpsi_host_model.pins.select_n <= 1'h0;
		i_hpsi_host_model.pins.read_write <= 1'h1;
		i_hpsi_host_model.pins.ctl0 <= 1'h1;
		i_hpsi_host_model.pins.addr <= 20'h00002;
		{i_hpsi_host_model.pins.strobe_a, i_hpsi_host_model.pins.strobe_b} <= 2'h3;
		repeat (6)
			@(posedge hclk);
		i_hpsi_host_model.pins.read_write <= 1'h0;
		i_hpsi_host_model.pins.ctl0 <= 1'h0;
		i_hpsi_host_model.pins.addr <= 20'h00004;
		repeat (6)
			@(posedge hclk);
		i_hpsi_host_model.pins.strobe_a <= 1'h0;
		pend();
		chk({rd[ST_SEL_LSB+:2], rd[ST_DIR_BIT]}, {SEL_DATA, 1'h1}, "latched ctl");
		ahb(1'h1, OFS_WDATA, 32'h0000c33c);
		for (int i = 0; i < 10 && pin_out.ready !== 1'h1; i++)
			@(posedge hclk);
		chk({pin_out.data_oe_n, pin_in.data}, {1'h0, 16'hc33c}, "latched read");
		i_hpsi_host_model.stop();
	endtask
	initial
	begin
		hclk = 1'h0;
		hresetn = 1'h0;
		hsel = 1'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		n_mismatch = 0;
		checks_done = 0;
		cyc = 0;
		repeat (3)
			@(posedge hclk);
		hresetn <= 1'h1;
		t_reset();
		t_sep();
		t_shared();
		t_hold();
		t_ignore();
		t_desel();
		t_astb();
		conclude();
	end
endmodule
